// File: logic/spcb_pkg.sv
// Constants of the serial port register block: offsets, fields, timing.
// Assumes a configuration fabric that presents byte addresses over APB.

package spcb_pkg;

    // ****************************************
    // Register offsets inside the block
    // ****************************************
    localparam logic [7:0] OFF_HEADER    = 8'h00;
    localparam logic [7:0] OFF_LINK_TO   = 8'h20;
    localparam logic [7:0] OFF_RESP_TO   = 8'h24;
    localparam logic [7:0] OFF_GEN_CTRL  = 8'h3c;
    localparam logic [7:0] OFF_LREQ      = 8'h40;
    localparam logic [7:0] OFF_LRESP     = 8'h44;
    localparam logic [7:0] OFF_ACK_TAG   = 8'h48;
    localparam logic [7:0] OFF_CTRL_TWO  = 8'h54;
    localparam logic [7:0] OFF_ERR_STAT  = 8'h58;
    localparam logic [31:0] BLOCK_SPAN   = 32'h0000_0100;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int TO_LSB      = 8;
    localparam int BIT_HOST    = 31;
    localparam int BIT_MEN     = 30;
    localparam int BIT_DISC    = 29;
    localparam int BIT_VALID   = 31;
    localparam int RTAG_LSB    = 5;
    localparam int BIT_FLUSH   = 31;
    localparam int RXTAG_LSB   = 24;
    localparam int ACCTAG_LSB  = 8;
    localparam int BIT_SCRBYP  = 29;
    localparam int BAUD_LSB    = 6;
    localparam int BIT_I2SUP   = 31;
    localparam int BIT_I2EN    = 30;
    localparam int BIT_I2USE   = 29;

    // ****************************************
    // Block type codes and timing
    // ****************************************
    localparam logic [15:0] TYPE_SW_RECOVERY = 16'h0002;
    localparam logic [15:0] TYPE_PLAIN       = 16'h0001;
    localparam logic [15:0] LANE_BLOCK_PTR   = 16'h0400;
    localparam int          FACTOR_SLOW_NS   = 256;
    localparam int          FACTOR_FAST_NS   = 204;
    localparam int          CLOCK_PERIOD_NS  = 50;

endpackage

// File: logic/spcb_csr.sv
// Serial port extended-features register bank with link timers.
// Assumes an APB master on CLOCK and port logic that pulses its events.

`timescale 1ns/1ns

module spcb_csr #(
    parameter logic [31:0] BLOCK_BASE    = 32'h0000_0100,
    parameter logic [15:0] NEXT_PTR      = spcb_pkg::LANE_BLOCK_PTR,
    parameter bit          SW_RECOVERY   = 1'b1,
    parameter bit          SECOND_IDLE_SEQUENCE_SUPPORT = 1'b1,
    parameter bit          RATE_LOW      = 1'b1,
    parameter int          FACTOR_NS     = spcb_pkg::FACTOR_SLOW_NS,
    parameter logic [23:0] LINK_TO_INIT  = 24'hff_ffff,
    parameter logic [23:0] RESP_TO_INIT  = 24'hff_ffff,
    parameter bit          HOST_INIT     = 1'b0,
    parameter bit          MEN_INIT      = 1'b1,
    parameter bit          DISC_INIT     = 1'b0,
    parameter bit          SECOND_IDLE_SEQUENCE_EN_INIT = 1'b1,
    parameter logic [9:0]  BAUD_SUPPORT  = 10'h000,
    parameter logic [3:0]  BAUD_SELECT   = 4'h0
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Port-wide control
    output logic             HOST,
    output logic             MASTER_ENABLE,
    output logic             DISCOVERED,
    input  wire logic        USER_REQ_VALID,
    input  wire logic        PORT_REQ_READY,
    output logic             USER_REQ_READY,
    // Link maintenance
    output logic             LREQ_SEND,
    output logic [2:0]       LREQ_CMD,
    input  wire logic        LREQ_SENT_NORESP,
    input  wire logic        LRESP_VALID,
    input  wire logic [5:0]  LRESP_TAG,
    input  wire logic [4:0]  LRESP_STATUS,
    // Tag tracking
    input  wire logic        RX_TAG_ADVANCE,
    input  wire logic        TX_TAG_ADVANCE,
    input  wire logic [5:0]  EXPECTED_ACCEPT_TAG,
    output logic [5:0]       EXPECTED_RX_TAG,
    output logic [5:0]       NEXT_TX_TAG,
    output logic [5:0]       LAST_ACK_TAG,
    output logic             FLUSH_UNACKED,
    output logic             RETRANSMIT,
    // Timers
    input  wire logic        PKT_SENT,
    input  wire logic        PKT_ACKED,
    input  wire logic        REQ_SENT,
    input  wire logic        RESP_RECEIVED,
    output logic             LINK_TIMEOUT,
    output logic             RESP_TIMEOUT,
    // Lane coding
    input  wire logic        SECOND_IDLE_SEQUENCE_IN_USE,
    output logic             SCRAMBLE_BYPASS,
    output logic             SECOND_IDLE_SEQUENCE_ENABLE
);

    // ****************************************
    // Types and constants
    // ****************************************
    localparam int RAW_PRE = (FACTOR_NS + spcb_pkg::CLOCK_PERIOD_NS / 2) / spcb_pkg::CLOCK_PERIOD_NS;
    localparam logic [3:0] PRE_LAST = 4'((RAW_PRE < 1 ? 1 : RAW_PRE) - 1);

    typedef struct packed {
        logic        run;
        logic [3:0]  pre;
        logic [23:0] cnt;
        logic        exp;
    } spcb_tmr_s;

    typedef struct packed {
        logic [31:0] rdata;
        logic [23:0] link_to;
        logic [23:0] resp_to;
        logic        host;
        logic        men;
        logic        disc;
        logic [2:0]  lreq_cmd;
        logic        lreq_send;
        logic        resp_valid;
        logic [5:0]  resp_tag;
        logic [4:0]  resp_stat;
        logic [5:0]  rx_tag;
        logic [5:0]  tx_tag;
        logic [5:0]  last_ack;
        logic        flush;
        logic        retx;
        logic        scr_byp;
        logic        second_idle_sequence_en;
        spcb_tmr_s   link_t;
        spcb_tmr_s   resp_t;
    } spcb_state_s;

    spcb_state_s st;
    spcb_state_s next_st;

    // ****************************************
    // Helpers
    // ****************************************
    // Coarse prescaler: the 33% tolerance covers rounding the factor to clocks
    function automatic spcb_tmr_s tmr_step(spcb_tmr_s t, logic start, logic stop, logic [23:0] lim);
        spcb_tmr_s n;
        n = t;
        n.exp = 1'b0;
        if (start) begin
            n.run = 1'b1;
            n.pre = 4'h0;
            n.cnt = 24'h00_0000;
        end else if (stop) begin
            n.run = 1'b0;
        end else if (t.run) begin
            if (t.pre == PRE_LAST) begin
                n.pre = 4'h0;
                n.cnt = t.cnt + 24'h00_0001;
                if (t.cnt + 24'h00_0001 >= lim) begin
                    n.exp = 1'b1;
                    n.run = 1'b0;
                end
            end else begin
                n.pre = t.pre + 4'h1;
            end
        end
        return n;
    endfunction

    logic [31:0] rel;
    logic        in_blk;
    logic [7:0]  off;
    logic        mapped;
    logic        wr_acc;
    logic        rd_acc;
    logic [31:0] rd_word;

    assign rel    = PADDR - BLOCK_BASE;
    assign in_blk = (PADDR >= BLOCK_BASE) && (rel < spcb_pkg::BLOCK_SPAN);
    assign off    = rel[7:0];
    assign wr_acc = PSEL && PENABLE && PWRITE && mapped;
    assign rd_acc = PSEL && PENABLE && !PWRITE && mapped;

    always_comb begin
        mapped = 1'b0;
        if (in_blk && off[1:0] == 2'b00) begin
            case (off)
                spcb_pkg::OFF_HEADER, spcb_pkg::OFF_LINK_TO, spcb_pkg::OFF_RESP_TO, spcb_pkg::OFF_GEN_CTRL,
                spcb_pkg::OFF_CTRL_TWO, spcb_pkg::OFF_ERR_STAT: begin
                    mapped = 1'b1;
                end
                spcb_pkg::OFF_LREQ, spcb_pkg::OFF_LRESP, spcb_pkg::OFF_ACK_TAG: begin
                    mapped = SW_RECOVERY;
                end
                default: begin
                    mapped = 1'b1; // Reserved words inside the block read zero
                end
            endcase
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        case (off)
            spcb_pkg::OFF_HEADER: begin
                rd_word = {NEXT_PTR, SW_RECOVERY ? spcb_pkg::TYPE_SW_RECOVERY : spcb_pkg::TYPE_PLAIN};
            end
            spcb_pkg::OFF_LINK_TO: begin
                rd_word[31:spcb_pkg::TO_LSB] = st.link_to;
            end
            spcb_pkg::OFF_RESP_TO: begin
                rd_word[31:spcb_pkg::TO_LSB] = st.resp_to;
            end
            spcb_pkg::OFF_GEN_CTRL: begin
                rd_word[spcb_pkg::BIT_HOST] = st.host;
                rd_word[spcb_pkg::BIT_MEN]  = st.men;
                rd_word[spcb_pkg::BIT_DISC] = st.disc;
            end
            spcb_pkg::OFF_LREQ: begin
                rd_word[2:0] = SW_RECOVERY ? st.lreq_cmd : 3'h0;
            end
            spcb_pkg::OFF_LRESP: begin
                if (SW_RECOVERY) begin
                    rd_word[spcb_pkg::BIT_VALID] = st.resp_valid;
                    rd_word[10:spcb_pkg::RTAG_LSB] = st.resp_tag;
                    rd_word[4:0] = st.resp_stat;
                end
            end
            spcb_pkg::OFF_ACK_TAG: begin
                if (SW_RECOVERY) begin
                    rd_word[29:spcb_pkg::RXTAG_LSB] = st.rx_tag;
                    rd_word[13:spcb_pkg::ACCTAG_LSB] = EXPECTED_ACCEPT_TAG;
                    rd_word[5:0] = st.tx_tag;
                end
            end
            spcb_pkg::OFF_CTRL_TWO: begin
                rd_word[spcb_pkg::BIT_SCRBYP] = st.scr_byp;
                rd_word[15:spcb_pkg::BAUD_LSB] = BAUD_SUPPORT;
                rd_word[3:0] = BAUD_SELECT;
            end
            spcb_pkg::OFF_ERR_STAT: begin
                rd_word[spcb_pkg::BIT_I2SUP] = SECOND_IDLE_SEQUENCE_SUPPORT;
                rd_word[spcb_pkg::BIT_I2EN]  = st.second_idle_sequence_en;
                rd_word[spcb_pkg::BIT_I2USE] = SECOND_IDLE_SEQUENCE_IN_USE;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.lreq_send = 1'b0;
        next_st.flush = 1'b0;
        next_st.retx = 1'b0;
        if (PSEL && !PENABLE) begin
            next_st.rdata = mapped ? rd_word : 32'h0000_0000;
        end
        if (RX_TAG_ADVANCE) begin
            next_st.rx_tag = st.rx_tag + 6'h01;
        end
        if (TX_TAG_ADVANCE) begin
            next_st.tx_tag = st.tx_tag + 6'h01;
        end
        // Clear by read first, so a same-cycle set below wins
        if (rd_acc && off == spcb_pkg::OFF_LRESP) begin
            next_st.resp_valid = 1'b0;
        end
        if (wr_acc) begin
            case (off)
                spcb_pkg::OFF_LINK_TO: begin
                    next_st.link_to = PWDATA[31:spcb_pkg::TO_LSB];
                end
                spcb_pkg::OFF_RESP_TO: begin
                    next_st.resp_to = PWDATA[31:spcb_pkg::TO_LSB];
                end
                spcb_pkg::OFF_GEN_CTRL: begin
                    next_st.host = PWDATA[spcb_pkg::BIT_HOST];
                    next_st.men  = PWDATA[spcb_pkg::BIT_MEN];
                    next_st.disc = PWDATA[spcb_pkg::BIT_DISC];
                end
                spcb_pkg::OFF_LREQ: begin
                    next_st.lreq_cmd  = PWDATA[2:0];
                    next_st.lreq_send = 1'b1;
                end
                spcb_pkg::OFF_ACK_TAG: begin
                    if (PWDATA[spcb_pkg::BIT_FLUSH]) begin
                        next_st.flush = 1'b1;
                        next_st.last_ack = next_st.tx_tag - 6'h01;
                    end else begin
                        next_st.rx_tag = PWDATA[29:spcb_pkg::RXTAG_LSB];
                        next_st.tx_tag = PWDATA[5:0];
                        next_st.retx = 1'b1;
                    end
                end
                spcb_pkg::OFF_CTRL_TWO: begin
                    next_st.scr_byp = SECOND_IDLE_SEQUENCE_SUPPORT && PWDATA[spcb_pkg::BIT_SCRBYP];
                end
                spcb_pkg::OFF_ERR_STAT: begin
                    if (SECOND_IDLE_SEQUENCE_SUPPORT && RATE_LOW) begin
                        next_st.second_idle_sequence_en = PWDATA[spcb_pkg::BIT_I2EN];
                    end
                end
                default: begin
                    next_st.rdata = next_st.rdata;
                end
            endcase
        end
        if (SW_RECOVERY && LRESP_VALID) begin
            next_st.resp_valid = 1'b1;
            next_st.resp_tag   = LRESP_TAG;
            next_st.resp_stat  = LRESP_STATUS;
        end
        if (SW_RECOVERY && LREQ_SENT_NORESP) begin
            next_st.resp_valid = 1'b1;
        end
        // Link timer covers packets and link-requests alike
        next_st.link_t = tmr_step(st.link_t, PKT_SENT || st.lreq_send, PKT_ACKED || LRESP_VALID,
                                  st.link_to);
        next_st.resp_t = tmr_step(st.resp_t, REQ_SENT, RESP_RECEIVED, st.resp_to);
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            st          <= '0;
            st.link_to  <= LINK_TO_INIT;
            st.resp_to  <= RESP_TO_INIT;
            st.host     <= HOST_INIT;
            st.men      <= MEN_INIT;
            st.disc     <= DISC_INIT;
            st.last_ack <= 6'h3f;
            st.second_idle_sequence_en <= SECOND_IDLE_SEQUENCE_SUPPORT && SECOND_IDLE_SEQUENCE_EN_INIT;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign PRDATA          = st.rdata;
    assign PREADY          = 1'b1;
    assign PSLVERR         = PSEL && PENABLE && !mapped;
    assign HOST            = st.host;
    assign MASTER_ENABLE   = st.men;
    assign DISCOVERED      = st.disc;
    assign USER_REQ_READY  = st.men && PORT_REQ_READY;
    assign LREQ_SEND       = st.lreq_send;
    assign LREQ_CMD        = st.lreq_cmd;
    assign EXPECTED_RX_TAG = st.rx_tag;
    assign NEXT_TX_TAG     = st.tx_tag;
    assign LAST_ACK_TAG    = st.last_ack;
    assign FLUSH_UNACKED   = st.flush;
    assign RETRANSMIT      = st.retx;
    assign LINK_TIMEOUT    = st.link_t.exp;
    assign RESP_TIMEOUT    = st.resp_t.exp;
    assign SCRAMBLE_BYPASS = st.scr_byp;
    assign SECOND_IDLE_SEQUENCE_ENABLE    = st.second_idle_sequence_en;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    a_header_read: assert property (
        PSEL && !PENABLE && in_blk && off == spcb_pkg::OFF_HEADER |=>
        PRDATA == {NEXT_PTR, SW_RECOVERY ? spcb_pkg::TYPE_SW_RECOVERY : spcb_pkg::TYPE_PLAIN})
        else $error("header read value wrong");

    a_lreq_one_pulse: assert property (
        wr_acc && off == spcb_pkg::OFF_LREQ |=> LREQ_SEND && LREQ_CMD == $past(PWDATA[2:0]) ##1 !LREQ_SEND)
        else $error("link request not sent once");

    a_master_refuse: assert property (
        wr_acc && off == spcb_pkg::OFF_GEN_CTRL && !PWDATA[spcb_pkg::BIT_MEN] |=> !USER_REQ_READY)
        else $error("user request accepted while disabled");

    a_user_refused: assert property (
        USER_REQ_VALID && !MASTER_ENABLE |-> !USER_REQ_READY)
        else $error("user request taken with master disabled");

    a_valid_set: assert property (
        SW_RECOVERY && (LRESP_VALID || LREQ_SENT_NORESP) |=> st.resp_valid)
        else $error("response valid not set");

    a_valid_read_clr: assert property (
        rd_acc && off == spcb_pkg::OFF_LRESP && !LRESP_VALID && !LREQ_SENT_NORESP |=> !st.resp_valid)
        else $error("response valid not cleared by read");

    a_flush_keeps_tags: assert property (
        wr_acc && off == spcb_pkg::OFF_ACK_TAG && PWDATA[spcb_pkg::BIT_FLUSH] && !RX_TAG_ADVANCE |=>
        $stable(EXPECTED_RX_TAG) && FLUSH_UNACKED && !RETRANSMIT)
        else $error("flush write altered receive tag");

    a_flush_reads_zero: assert property (
        PSEL && !PENABLE && in_blk && off == spcb_pkg::OFF_ACK_TAG |=> !PRDATA[spcb_pkg::BIT_FLUSH])
        else $error("flush bit read as one");

    a_timeout_pulse: assert property (
        LINK_TIMEOUT |=> !LINK_TIMEOUT)
        else $error("link timeout longer than a cycle");

    a_no_bypass_idle1: assert property (
        !SECOND_IDLE_SEQUENCE_SUPPORT |-> !SCRAMBLE_BYPASS)
        else $error("scrambler bypassed without second idle");

endmodule

// File: tb/spcb_fabric.sv
// APB master standing in for the configuration fabric.
// Assumes the bench strobes go for one cycle per request and waits for done.

`timescale 1ns/1ns

module spcb_fabric (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Bench request and result
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic             err,
    output logic [31:0]      rdata,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {psel, penable, pwrite, done, err} <= 5'h00;
            {paddr, pwdata, rdata} <= 96'h0;
        end else begin
            done <= 1'b0;
            if (go && !psel) begin
                psel <= 1'b1;
                pwrite <= wr;
                paddr <= addr;
                pwdata <= wdata;
            end else if (psel && !penable) begin
                penable <= 1'b1;
            end else if (penable && pready) begin
                // Released lines flip so a stale value never looks valid
                psel <= 1'b0;
                penable <= 1'b0;
                paddr <= ~paddr;
                pwdata <= ~pwdata;
                done <= 1'b1;
                err <= pslverr;
                rdata <= pwrite ? 32'h0 : prdata;
            end
        end
    end
endmodule

// File: tb/tb.sv
// Self-checking bench for the serial port register block.
// Assumes spcb_csr and the fabric model; expectations queue per APB transfer.

`timescale 1ns/1ns

`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s expected %h seen %h", n, e, g); end end

module tb;
    // ****************************************
    // Signals
    // ****************************************
    localparam logic [31:0] B = 32'h0000_0100;
    logic CLOCK = 1'b0, RESET = 1'b1, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [31:0] PADDR, PWDATA, PRDATA, addr = 32'h0, wdata = 32'h0, rdata, rnd;
    logic HOST, MASTER_ENABLE, DISCOVERED, USER_REQ_READY, LREQ_SEND, FLUSH_UNACKED, RETRANSMIT;
    logic LINK_TIMEOUT, RESP_TIMEOUT, SCRAMBLE_BYPASS, SECOND_IDLE_SEQUENCE_ENABLE, done, err;
    logic [2:0] LREQ_CMD;
    logic [5:0] EXPECTED_RX_TAG, NEXT_TX_TAG, LAST_ACK_TAG, LRESP_TAG = 6'h0, EXPECTED_ACCEPT_TAG;
    logic [4:0] LRESP_STATUS = 5'h0;
    logic USER_REQ_VALID = 1'b0, PORT_REQ_READY = 1'b1, LREQ_SENT_NORESP, LRESP_VALID;
    logic RX_TAG_ADVANCE, TX_TAG_ADVANCE, PKT_SENT, PKT_ACKED;
    logic REQ_SENT, RESP_RECEIVED, SECOND_IDLE_SEQUENCE_IN_USE, go = 1'b0, wr = 1'b0;
    logic [1:0] seen;
    logic [7:0] stb = 8'h00;
    logic [32:0] exp_q[$], exp_v;
    int err_count = 0, checks_done = 0;
    // One strobe vector, so every event pulse is driven from one place
    localparam logic [7:0] S_LRESP = 8'h01, S_NORESP = 8'h02, S_TXADV = 8'h04, S_PSENT = 8'h10;
    localparam logic [7:0] S_PACK = 8'h20, S_RSENT = 8'h40, S_RRCV = 8'h80;
    assign {RESP_RECEIVED, REQ_SENT, PKT_ACKED, PKT_SENT, RX_TAG_ADVANCE, TX_TAG_ADVANCE, LREQ_SENT_NORESP,
            LRESP_VALID} = stb;

    always #25 CLOCK = ~CLOCK;

    spcb_csr #(.LINK_TO_INIT(24'h000004)) u_spcb_csr (.*);

    spcb_fabric u_spcb_fabric (.clk(CLOCK), .rst(RESET), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
        .done(done), .err(err), .rdata(rdata), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
        .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input int w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        exp_q.push_back(e);
        go <= 1'b1;
        wr <= w[0];
        addr <= a;
        wdata <= d;
        @(posedge CLOCK);
        go <= 1'b0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge CLOCK);
            n++;
        end
        if (n >= 20) err_count++;
    endtask

    task automatic pulse(input logic [7:0] m);
        stb <= m;
        @(posedge CLOCK);
        stb <= 8'h00;
        @(posedge CLOCK);
    endtask

    // Span allows the loose accuracy the timers are held to
    task automatic timed(input logic [7:0] m, input logic sel, input int cnt);
        int n, e;
        n = 0;
        e = cnt * spcb_pkg::FACTOR_SLOW_NS / spcb_pkg::CLOCK_PERIOD_NS;
        pulse(m);
        while ((sel ? RESP_TIMEOUT : LINK_TIMEOUT) !== 1'b1 && n < 300) begin
            @(posedge CLOCK);
            n++;
        end
        `CHK("timeout span", 1'b1, (n + 2 >= e * 2 / 3 && n + 2 <= e * 4 / 3 + 2))
        @(posedge CLOCK);
        `CHK("timeout pulse", 1'b0, (sel ? RESP_TIMEOUT : LINK_TIMEOUT))
    endtask

    // ****************************************
    // Result monitor
    // ****************************************
    always @(posedge CLOCK) begin
        if (done === 1'b1) begin
            exp_v = exp_q.pop_front();
            `CHK("apb result", exp_v, {err, rdata})
        end
    end

    initial begin
        repeat (20000) @(posedge CLOCK);
        err_count++;
        print_verdict();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rnd = $urandom(32'h6228);
        rnd = $urandom();
        EXPECTED_ACCEPT_TAG <= rnd[5:0];
        SECOND_IDLE_SEQUENCE_IN_USE <= rnd[22];
        repeat (20) @(posedge CLOCK);
        RESET <= 1'b0;
        USER_REQ_VALID <= 1'b1;
        @(posedge CLOCK);
        apb(0, B, 0, {1'b0, 16'h0400, 16'h0002});
        apb(0, B + 32'h20, 0, 33'h000000400);
        apb(0, B + 32'h3c, 0, 33'h040000000);
        apb(0, B + 32'h04, 0, 33'h0);
        apb(0, 32'h0000_0020, 0, {1'b1, 32'h0});
        apb(1, B + 32'h22, 32'hffff_ffff, {1'b1, 32'h0});
        apb(1, B + 32'h24, 32'h0000_03ff, 33'h0);
        apb(0, B + 32'h24, 0, 33'h000000300);
        `CHK("user ready", 1'b1, USER_REQ_READY)
        apb(1, B + 32'h3c, 32'ha000_0000, 33'h0);
        `CHK("port bits", 4'b1010, {HOST, MASTER_ENABLE, DISCOVERED, USER_REQ_READY})
        apb(1, B + 32'h40, rnd, 33'h0);
        `CHK("lreq pulse", {1'b1, rnd[2:0]}, {LREQ_SEND, LREQ_CMD})
        @(posedge CLOCK);
        `CHK("lreq end", 1'b0, LREQ_SEND)
        apb(0, B + 32'h40, 0, {30'h0, rnd[2:0]});
        LRESP_TAG <= rnd[16:11];
        LRESP_STATUS <= rnd[21:17];
        pulse(S_LRESP);
        apb(0, B + 32'h44, 0, {2'b01, 20'h0, rnd[16:11], rnd[21:17]});
        apb(0, B + 32'h44, 0, {2'b00, 20'h0, rnd[16:11], rnd[21:17]});
        pulse(S_NORESP);
        apb(0, B + 32'h44, 0, {2'b01, 20'h0, rnd[16:11], rnd[21:17]});
        pulse(S_TXADV);
        `CHK("tx advance", 6'h01, NEXT_TX_TAG)
        apb(1, B + 32'h48, 32'h1500_3f2a, 33'h0);
        `CHK("tag load", {1'b1, 6'h15, 6'h2a}, {RETRANSMIT, EXPECTED_RX_TAG, NEXT_TX_TAG})
        apb(0, B + 32'h48, 0, {9'h015, 10'h0, rnd[5:0], 8'h2a});
        apb(1, B + 32'h88 - 32'h40, 32'h8c00_0011, 33'h0);
        `CHK("flush", {1'b1, 6'h29, 6'h15, 6'h2a},
            {FLUSH_UNACKED, LAST_ACK_TAG, EXPECTED_RX_TAG, NEXT_TX_TAG})
        apb(0, B + 32'h48, 0, {9'h015, 10'h0, rnd[5:0], 8'h2a});
        apb(1, B + 32'h54, 32'hffff_ffff, 33'h0);
        `CHK("scramble bypass", 1'b1, SCRAMBLE_BYPASS)
        apb(0, B + 32'h54, 0, 33'h020000000);
        apb(0, B + 32'h58, 0, {3'b011, SECOND_IDLE_SEQUENCE_IN_USE, 29'h0});
        apb(1, B + 32'h58, 32'h0, 33'h0);
        `CHK("second_idle_sequence enable", 1'b0, SECOND_IDLE_SEQUENCE_ENABLE)
        apb(0, B + 32'h58, 0, {3'b010, SECOND_IDLE_SEQUENCE_IN_USE, 29'h0});
        // Acknowledge and response stop both timers before they run out
        pulse(S_PSENT | S_RSENT);
        pulse(S_PACK | S_RRCV);
        seen = 2'b00;
        repeat (30) begin
            @(posedge CLOCK);
            seen = seen | {RESP_TIMEOUT, LINK_TIMEOUT};
        end
        `CHK("stopped timers", 2'b00, seen)
        pulse(S_PSENT);
        repeat (8) @(posedge CLOCK);
        timed(S_PSENT, 1'b0, 4);
        timed(S_RSENT, 1'b1, 3);
        print_verdict();
    end
endmodule
